/* File: verification/tb_timer_pwm_pulse_capture.sv */
`timescale 1ns/100ps
`include "tpc_timer_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %0h want %0h", $time, (g), (e)); end end

module tb_timer_pwm_pulse_capture;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o, r;
  logic        pready_o, pslverr_o, ext_clock_pin_i, capture_input_pin_i, e;
  logic        timer_out_o, timer_out_oe_o, match_a_flag_o, match_p_flag_o;
  int          failures = 0;
  int          checks_done = 0;
  int          hi, c0;
  // PWM rows: control byte, compare A, compare P, window, high cycles, flags.
  logic [7:0]  t_c1[8] = '{8'hA9, 8'hA8, 8'hAA, 8'hAC, 8'h88, 8'h98, 8'hA9, 8'hA9};
  logic [9:0]  t_a[8]  = '{10'h20, 10'hC8, 10'h12C, 10'h20, 10'h20, 10'h20, 10'h100, 10'h200};
  logic [2:0]  t_p[8]  = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h7, 3'h0};
  int          t_w[8]  = '{256, 256, 600, 256, 256, 256, 896, 1024};
  int          t_h[8]  = '{64, 256, 256, 192, 0, 256, 256, 512};
  logic [1:0]  t_s[8]  = '{2'h3, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

  tpc_timer #(.CNT_W(10)) u_tpc_timer (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clock_pin_i(ext_clock_pin_i),
    .capture_input_pin_i(capture_input_pin_i), .timer_out_o(timer_out_o),
    .timer_out_oe_o(timer_out_oe_o), .match_a_flag_o(match_a_flag_o),
    .match_p_flag_o(match_p_flag_o));

  tpc_pin_model u_tpc_pin_model (
    .sys_clk_i(sys_clk_i), .timer_out_i(timer_out_o), .timer_out_oe_i(timer_out_oe_o),
    .ext_clock_pin_o(ext_clock_pin_i), .capture_input_pin_o(capture_input_pin_i));

  // Free-running 50 MHz clock.
  always #10 sys_clk_i = ~sys_clk_i;

  // One bus transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask

  // Counts cycles with the pad high, as the far side sees it, over a window.
  task automatic meas(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge sys_clk_i);
      hi += (u_tpc_pin_model.pad_lvl === 1'b1);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog: some four times the roughly 4700 cycles the tests need.
  initial begin
    #400_000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(`TPC_ADDR_CMPA, {22'h0, t_a[i]});
      wr(`TPC_ADDR_CMPP, {29'h0, t_p[i]});
      wr(`TPC_ADDR_CTRL1, {24'h0, t_c1[i]});
      wr(`TPC_ADDR_CTRL0, 32'h1);
      repeat (4) @(posedge sys_clk_i);
      meas(t_w[i]);
      `CHK(hi, t_h[i])
      `CHK(timer_out_oe_o, 1'b1)
      wr(`TPC_ADDR_CTRL0, 32'h0);
      rd(`TPC_ADDR_STATUS);
      `CHK(r[1:0], t_s[i])
      wr(`TPC_ADDR_STATUS, 32'h3);
    end
    // Reset values, widths, a read-only count and an unmapped place.
    resetn_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      `CHK({e, r}, 33'h0)
    end
    rd(8'h18);
    `CHK({e, r}, 33'h1_0000_0000)
    wr(`TPC_ADDR_COUNT, 32'h155);
    wr(`TPC_ADDR_CMPA, 32'hFFFF_FFFF);
    wr(`TPC_ADDR_CMPP, 32'hFFFF_FFFF);
    rd(`TPC_ADDR_CMPA);
    `CHK(r, 32'h3FF)
    rd(`TPC_ADDR_CMPP);
    `CHK(r, 32'h7)
    rd(`TPC_ADDR_COUNT);
    `CHK(r, 32'h0)
    // Single pulse, first from the trigger pin, then by software.
    wr(`TPC_ADDR_CMPA, 32'h32);
    wr(`TPC_ADDR_CTRL1, 32'hB8);
    fork
      u_tpc_pin_model.trig();
      meas(80);
    join
    `CHK(hi >= 49 && hi <= 53, 1'b1)
    rd(`TPC_ADDR_CTRL0);
    `CHK(r[0], 1'b0)
    rd(`TPC_ADDR_STATUS);
    `CHK(r[0], 1'b1)
    wr(`TPC_ADDR_CTRL0, 32'h1);
    repeat (5) @(posedge sys_clk_i);
    `CHK(timer_out_o, 1'b1)
    wr(`TPC_ADDR_CTRL0, 32'h0);
    repeat (3) @(posedge sys_clk_i);
    `CHK(timer_out_o, 1'b0)
    rd(`TPC_ADDR_COUNT);
    `CHK(r > 32'h3 && r < 32'h14, 1'b1)
    // Capture on every edge selection, both pin directions each.
    wr(`TPC_ADDR_CMPP, 32'h0);
    wr(`TPC_ADDR_CTRL1, 32'h40);
    wr(`TPC_ADDR_CTRL0, 32'h1);
    for (int pf = 0; pf < 4; pf++) begin
      wr(`TPC_ADDR_CTRL1, 32'h40 | (pf << 4));
      for (int v = 1; v >= 0; v--) begin
        wr(`TPC_ADDR_STATUS, 32'h1);
        u_tpc_pin_model.set_cap(v[0]);
        repeat (8) @(posedge sys_clk_i);
        rd(`TPC_ADDR_STATUS);
        `CHK(r[0], (pf == 2) || (pf == 1 - v))
      end
    end
    // Init and polarity set on purpose: capture mode must ignore them.
    wr(`TPC_ADDR_CTRL1, 32'h4D);
    rd(`TPC_ADDR_COUNT);
    c0 = r;
    u_tpc_pin_model.set_cap(1'b1);
    repeat (8) @(posedge sys_clk_i);
    rd(`TPC_ADDR_CMPA);
    `CHK(r > c0 && r < c0 + 12, 1'b1)
    `CHK({timer_out_oe_o, timer_out_o}, 2'h0)
    wr(`TPC_ADDR_CMPP, 32'h1);
    wr(`TPC_ADDR_CTRL0, 32'h0);
    wr(`TPC_ADDR_CTRL0, 32'h1);
    wr(`TPC_ADDR_STATUS, 32'h3);
    repeat (300) @(posedge sys_clk_i);
    rd(`TPC_ADDR_COUNT);
    `CHK(r < 32'h80, 1'b1)
    rd(`TPC_ADDR_STATUS);
    `CHK(r[1:0], 2'h2)
    // Divide-by-four clock: one count every fourth cycle after the restart.
    wr(`TPC_ADDR_CTRL0, 32'h0);
    wr(`TPC_ADDR_CTRL0, 32'h3);
    repeat (40) @(posedge sys_clk_i);
    rd(`TPC_ADDR_COUNT);
    `CHK(r, 32'hA)
    // Pin-driven clock: one count per rising edge on the external pin.
    wr(`TPC_ADDR_CTRL0, 32'h0);
    wr(`TPC_ADDR_CTRL0, 32'h7);
    repeat (5) u_tpc_pin_model.trig();
    repeat (4) @(posedge sys_clk_i);
    rd(`TPC_ADDR_COUNT);
    `CHK(r, 32'h5)
    end_sim();
  end
endmodule // tb_timer_pwm_pulse_capture

bind tpc_timer tpc_timer_chk #(.CNT_W(CNT_W)) u_tpc_timer_chk (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clock_pin_i(ext_clock_pin_i),
  .capture_input_pin_i(capture_input_pin_i), .timer_out_o(timer_out_o),
  .timer_out_oe_o(timer_out_oe_o), .match_a_flag_o(match_a_flag_o),
  .match_p_flag_o(match_p_flag_o));

/* File: verification/tpc_pin_model.sv */
`timescale 1ns/100ps

module tpc_pin_model (
  // Clock.
  input  logic sys_clk_i,
  // Pins outside the timer.
  input  logic timer_out_i,
  input  logic timer_out_oe_i,
  output logic ext_clock_pin_o,
  output logic capture_input_pin_o
);
  // Level the pad shows; a weak pull-down holds it low while the timer lets go.
  logic pad_lvl;
  assign pad_lvl = timer_out_oe_i ? timer_out_i : 1'b0;

  // Pins idle low from time zero.
  initial begin
    ext_clock_pin_o = 1'b0;
    capture_input_pin_o = 1'b0;
  end

  // Trigger edge; held three cycles since narrow pulses may be dropped.
  task automatic trig();
    @(posedge sys_clk_i);
    ext_clock_pin_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    ext_clock_pin_o <= 1'b0;
  endtask

  // New capture level, then held at least two cycles.
  task automatic set_cap(input logic v);
    @(posedge sys_clk_i);
    capture_input_pin_o <= v;
    repeat (2) @(posedge sys_clk_i);
  endtask
endmodule // tpc_pin_model

/* File: verification/tpc_timer_chk.sv */
`timescale 1ns/100ps
`include "tpc_timer_regs.vh"

module tpc_timer_chk #(
  parameter CNT_W = 10
) (
  // Clock, reset and register bus.
  input logic        sys_clk_i,
  input logic        resetn_i,
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [7:0]  paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        pslverr_o,
  // Pins and flags.
  input logic        ext_clock_pin_i,
  input logic        capture_input_pin_i,
  input logic        timer_out_o,
  input logic        timer_out_oe_o,
  input logic        match_a_flag_o,
  input logic        match_p_flag_o
);
  logic [7:0] ctl_q;
  logic       on_q;
  wire        wr_w  = psel_i & penable_i & pwrite_i & pready_o;
  wire        cap_w = (ctl_q[7:6] == `TPC_MODE_CAP) & on_q;

  // Shadow of the control bytes; kept from completed writes so no body signal is needed.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_q <= 8'h00;
      on_q  <= 1'b0;
    end else if (wr_w && paddr_i == `TPC_ADDR_CTRL1) begin
      ctl_q <= pwdata_i[7:0];
    end else if (wr_w && paddr_i == `TPC_ADDR_CTRL0) begin
      on_q <= pwdata_i[0];
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_oe_low;
    !timer_out_oe_o |-> !timer_out_o;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin level while not driven");

  property p_oe_mode;
    timer_out_oe_o == $past(ctl_q[7:6] == `TPC_MODE_PWM);
  endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("output enable off mode");

  property p_err;
    psel_i && penable_i |-> pslverr_o == (paddr_i > `TPC_ADDR_STATUS || paddr_i[1:0] != 2'h0);
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");

  property p_rd_w;
    psel_i && penable_i && !pwrite_i && paddr_i == `TPC_ADDR_CMPA |-> prdata_o[31:CNT_W] == '0;
  endproperty
  a_rd_w: assert property (p_rd_w) else $error("compare A too wide");

  property p_fla;
    $fell(match_a_flag_o) |-> $past(wr_w && paddr_i == `TPC_ADDR_STATUS && pwdata_i[0]);
  endproperty
  a_fla: assert property (p_fla) else $error("flag A lost");

  property p_flp;
    $fell(match_p_flag_o) |-> $past(wr_w && paddr_i == `TPC_ADDR_STATUS && pwdata_i[1]);
  endproperty
  a_flp: assert property (p_flp) else $error("flag P lost");

  property p_cap;
    cap_w && ctl_q[5:4] == `TPC_CAP_RISE && $rose(capture_input_pin_i) |-> ##[1:6] match_a_flag_o;
  endproperty
  a_cap: assert property (p_cap) else $error("capture flag late");

  property p_nocap;
    cap_w && ctl_q[5:4] == 2'h3 && $past(ctl_q[5:4]) == 2'h3 |-> !$rose(match_a_flag_o);
  endproperty
  a_nocap: assert property (p_nocap) else $error("capture while off");

  property p_pulse;
    $rose(match_a_flag_o) && ctl_q[7:4] == 4'hB |-> ##[0:2] timer_out_o == (~ctl_q[3] ^ ctl_q[2]);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse not ended");
endmodule // tpc_timer_chk

/* File: verilog/tpc_timer.v */
`timescale 1ns/100ps
`include "tpc_timer_regs.vh"

module tpc_timer #(
  parameter CNT_W = 10
) (
  // Clock and reset.
  input  wire             sys_clk_i,
  input  wire             resetn_i,
  // APB slave.
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [7:0]       paddr_i,
  input  wire [31:0]      pwdata_i,
  output wire [31:0]      prdata_o,
  output wire             pready_o,
  output wire             pslverr_o,
  // Timer pins.
  input  wire             ext_clock_pin_i,
  input  wire             capture_input_pin_i,
  output wire             timer_out_o,
  output wire             timer_out_oe_o,
  // Sticky flags.
  output wire             match_a_flag_o,
  output wire             match_p_flag_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam [2:0] RST_CTRL0 = `TPC_RST_CTRL0;
  localparam [7:0] RST_CTRL1 = `TPC_RST_CTRL1;

  reg  [1:0]       ext_sync_q, cap_sync_q;
  reg              ext_prev_q, cap_prev_q, on_prev_q;
  reg              counter_on_q, counter_on_d;
  reg  [1:0]       clk_sel_q, op_mode_q, pin_function_q;
  reg              output_init_level_q, output_polarity_q;
  reg              period_duty_swap_q, clear_select_q;
  reg  [CNT_W-1:0] compare_a_value_q, cnt_q, cnt_d;
  reg  [2:0]       compare_p_value_q;
  reg  [3:0]       pre_q, div_last;
  reg              match_a_flag_q, match_p_flag_q, cap_pend_q;
  reg              out_q, out_d, oe_q;
  reg  [31:0]      prdata_q, rd_mux;
  reg              addr_ok, cap_edge;

  wire             ext_rise, cap_rise, cap_fall;
  wire             setup_rd, acc_wr;
  wire             wr_ctrl0, wr_ctrl1, wr_cmpa, wr_cmpp, wr_status;
  wire             tick, half_tick, on_rise, run;
  wire [CNT_W:0]   cnt_inc, cnt_ext, p_len, a_len;
  wire [CNT_W:0]   period_len, duty_len;
  wire             a_hit, p_hit, period_hit;
  wire             pwm_mode, sp_mode, cap_mode;
  wire             pwm_on, cap_evt, a_set, p_set;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Two flops per pin; only the second stage feeds the edge detectors.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_sync_q <= 2'h0;
      ext_prev_q <= 1'b0;
      cap_sync_q <= 2'h0;
      cap_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_clock_pin_i};
      ext_prev_q <= ext_sync_q[1];
      cap_sync_q <= {cap_sync_q[0], capture_input_pin_i};
      cap_prev_q <= cap_sync_q[1];
    end
  end

  assign ext_rise = ext_sync_q[1] & ~ext_prev_q;
  assign cap_rise = cap_sync_q[1] & ~cap_prev_q;
  assign cap_fall = ~cap_sync_q[1] & cap_prev_q;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  // Zero wait states: read data is captured in the setup cycle so that it
  // comes from a flop during the access cycle.
  assign setup_rd  = psel_i & ~penable_i & ~pwrite_i;
  assign acc_wr    = psel_i & penable_i & pwrite_i;
  assign wr_ctrl0  = acc_wr & (paddr_i == `TPC_ADDR_CTRL0);
  assign wr_ctrl1  = acc_wr & (paddr_i == `TPC_ADDR_CTRL1);
  assign wr_cmpa   = acc_wr & (paddr_i == `TPC_ADDR_CMPA);
  assign wr_cmpp   = acc_wr & (paddr_i == `TPC_ADDR_CMPP);
  assign wr_status = acc_wr & (paddr_i == `TPC_ADDR_STATUS);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign prdata_o  = prdata_q;

  // Read mux; reserved bits read as zero.
  always @* begin
    addr_ok = 1'b1;
    rd_mux  = 32'h00000000;
    case (paddr_i)
      `TPC_ADDR_CTRL0: begin
        rd_mux[`TPC_C0_CKS_HI:`TPC_C0_CKS_LO] = clk_sel_q;
        rd_mux[`TPC_C0_ON] = counter_on_q;
      end
      `TPC_ADDR_CTRL1: begin
        rd_mux[`TPC_C1_MODE_HI:`TPC_C1_MODE_LO] = op_mode_q;
        rd_mux[`TPC_C1_PF_HI:`TPC_C1_PF_LO]     = pin_function_q;
        rd_mux[`TPC_C1_INIT]   = output_init_level_q;
        rd_mux[`TPC_C1_POL]    = output_polarity_q;
        rd_mux[`TPC_C1_SWAP]   = period_duty_swap_q;
        rd_mux[`TPC_C1_CLRSEL] = clear_select_q;
      end
      `TPC_ADDR_COUNT:  rd_mux[CNT_W-1:0] = cnt_q;
      `TPC_ADDR_CMPA:   rd_mux[CNT_W-1:0] = compare_a_value_q;
      `TPC_ADDR_CMPP:   rd_mux[2:0] = compare_p_value_q;
      `TPC_ADDR_STATUS: begin
        rd_mux[`TPC_ST_MAF] = match_a_flag_q;
        rd_mux[`TPC_ST_MPF] = match_p_flag_q;
      end
      default: addr_ok = 1'b0;
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_q <= 32'h00000000;
    end else if (setup_rd) begin
      prdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // The clear-select bit is stored for software but no mode built here
  // reads it.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_sel_q           <= RST_CTRL0[`TPC_C0_CKS_HI:`TPC_C0_CKS_LO];
      op_mode_q           <= RST_CTRL1[`TPC_C1_MODE_HI:`TPC_C1_MODE_LO];
      pin_function_q      <= 2'h0;
      output_init_level_q <= 1'b0;
      output_polarity_q   <= 1'b0;
      period_duty_swap_q  <= 1'b0;
      clear_select_q      <= 1'b0;
      compare_p_value_q   <= `TPC_RST_CMPP;
    end else begin
      if (wr_ctrl0) begin
        clk_sel_q <= pwdata_i[`TPC_C0_CKS_HI:`TPC_C0_CKS_LO];
      end
      if (wr_ctrl1) begin
        op_mode_q           <= pwdata_i[`TPC_C1_MODE_HI:`TPC_C1_MODE_LO];
        pin_function_q      <= pwdata_i[`TPC_C1_PF_HI:`TPC_C1_PF_LO];
        output_init_level_q <= pwdata_i[`TPC_C1_INIT];
        output_polarity_q   <= pwdata_i[`TPC_C1_POL];
        period_duty_swap_q  <= pwdata_i[`TPC_C1_SWAP];
        clear_select_q      <= pwdata_i[`TPC_C1_CLRSEL];
      end
      if (wr_cmpp) begin
        compare_p_value_q <= pwdata_i[2:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------------
  // The external pin as clock gives one tick per synchronised rising edge,
  // so it must be well below half the system clock.
  always @* begin
    case (clk_sel_q)
      `TPC_CKS_DIV4:  div_last = `TPC_DIV4_LAST;
      `TPC_CKS_DIV16: div_last = `TPC_DIV16_LAST;
      default:        div_last = 4'h0;
    endcase
  end

  assign tick      = (clk_sel_q == `TPC_CKS_EXT) ? ext_rise : (pre_q == div_last);
  assign half_tick = (clk_sel_q == `TPC_CKS_EXT) ? ext_rise :
                     (pre_q == {1'b0, div_last[3:1]});

  // Prescaler holds at zero while stopped so the first tick is a full one.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pre_q <= 4'h0;
    end else if (!counter_on_q || tick) begin
      pre_q <= 4'h0;
    end else begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Compare logic
  // ----------------------------------------------------------------------
  assign pwm_mode = (op_mode_q == `TPC_MODE_PWM) & (pin_function_q != `TPC_PF_PULSE);
  assign sp_mode  = (op_mode_q == `TPC_MODE_PWM) & (pin_function_q == `TPC_PF_PULSE);
  assign cap_mode = (op_mode_q == `TPC_MODE_CAP);
  assign on_rise  = counter_on_q & ~on_prev_q;
  assign run      = counter_on_q & tick;
  assign cnt_ext  = {1'b0, cnt_q};
  assign cnt_inc  = cnt_ext + 11'h001;

  // A compare P value of zero stands for the full 10-bit range.
  assign p_len = (compare_p_value_q == 3'h0) ? `TPC_FULL_COUNT :
                 {1'b0, compare_p_value_q, `TPC_P_STEP};
  assign a_len = (compare_a_value_q == 10'h000) ? `TPC_FULL_COUNT :
                 {1'b0, compare_a_value_q};

  // Matches fire on the tick that finishes the counted length.
  assign a_hit = run & (cnt_inc == a_len);
  assign p_hit = run & (cnt_inc == p_len);

  assign period_len = period_duty_swap_q ? a_len : p_len;
  // A compare A duty of zero gives a flat inactive output; with the swap, a compare P of zero gives a full one.
  assign duty_len   = period_duty_swap_q ? p_len : {1'b0, compare_a_value_q};
  assign period_hit = period_duty_swap_q ? a_hit : p_hit;

  // Count stays below the period, so a duty at or past it is always on.
  assign pwm_on = (cnt_ext < duty_len);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Single pulse never clears on a match; it clears only on a start.
  always @* begin
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = {CNT_W{1'b0}};
    end else if (run) begin
      if ((pwm_mode && period_hit) || (cap_mode && p_hit)) begin
        cnt_d = {CNT_W{1'b0}};
      end else begin
        cnt_d = cnt_inc[CNT_W-1:0];
      end
    end
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q     <= {CNT_W{1'b0}};
      on_prev_q <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      on_prev_q <= counter_on_q;
    end
  end

  // ----------------------------------------------------------------------
  // Counter-on control
  // ----------------------------------------------------------------------
  // A software write wins, then a trigger edge, then the A-match clear,
  // so a trigger in the match cycle keeps the counter on, and the count runs on uncleared.
  always @* begin
    counter_on_d = counter_on_q;
    if (sp_mode && a_hit) begin
      counter_on_d = 1'b0;
    end
    if (sp_mode && ext_rise) begin
      counter_on_d = 1'b1;
    end
    if (wr_ctrl0) begin
      counter_on_d = pwdata_i[`TPC_C0_ON];
    end
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      counter_on_q <= 1'b0;
    end else begin
      counter_on_q <= counter_on_d;
    end
  end

  // ----------------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------------
  // No glitch filter: short pulses are still taken, which is allowed.
  always @* begin
    case (pin_function_q)
      `TPC_CAP_RISE: cap_edge = cap_rise;
      `TPC_CAP_FALL: cap_edge = cap_fall;
      `TPC_CAP_BOTH: cap_edge = cap_rise | cap_fall;
      default:       cap_edge = 1'b0;
    endcase
  end

  // Capture only while counting; a stopped timer clock gives stale values.
  assign cap_evt = cap_mode & counter_on_q & cap_edge;

  // The latch happens on the detection cycle; the flag waits for the next
  // half timer period after it.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_a_value_q <= `TPC_RST_CMPA;
      cap_pend_q        <= 1'b0;
    end else begin
      if (cap_evt) begin
        compare_a_value_q <= cnt_q;
      end else if (wr_cmpa) begin
        compare_a_value_q <= pwdata_i[CNT_W-1:0];
      end
      if (cap_evt) begin
        cap_pend_q <= 1'b1;
      end else if (half_tick || !cap_mode) begin
        cap_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Match flags
  // ----------------------------------------------------------------------
  assign a_set = ((pwm_mode | sp_mode) & a_hit)
               | (cap_mode & cap_pend_q & half_tick);
  assign p_set = (pwm_mode | cap_mode) & p_hit;

  // Write one to clear; a set in the same cycle wins.
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
    end else begin
      match_a_flag_q <= (match_a_flag_q & ~(wr_status & pwdata_i[`TPC_ST_MAF])) | a_set;
      match_p_flag_q <= (match_p_flag_q & ~(wr_status & pwdata_i[`TPC_ST_MPF])) | p_set;
    end
  end

  assign match_a_flag_o = match_a_flag_q;
  assign match_p_flag_o = match_p_flag_q;

  // ----------------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------------
  // The initial level doubles as the active level of the waveform; the
  // polarity bit then inverts all of it but the start cycle, which shows the initial level uninverted.
  always @* begin
    out_d = out_q;
    if (cap_mode || (op_mode_q != `TPC_MODE_PWM)) begin
      out_d = 1'b0;
    end else if (on_rise) begin
      out_d = output_init_level_q;
    end else if (sp_mode) begin
      out_d = (counter_on_q ? output_init_level_q : ~output_init_level_q)
              ^ output_polarity_q;
    end else begin
      case (pin_function_q)
        `TPC_PF_INACT: out_d = ~output_init_level_q ^ output_polarity_q;
        `TPC_PF_ACT:   out_d = output_init_level_q ^ output_polarity_q;
        default: out_d = (pwm_on ? output_init_level_q : ~output_init_level_q)
                         ^ output_polarity_q;
      endcase
    end
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      out_q <= out_d;
      oe_q  <= (op_mode_q == `TPC_MODE_PWM);
    end
  end

  assign timer_out_o    = out_q;
  assign timer_out_oe_o = oe_q;

endmodule // tpc_timer

/* File: verilog/tpc_timer_regs.vh */
`ifndef TPC_TIMER_REGS_VH
`define TPC_TIMER_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TPC_ADDR_CTRL0   8'h00
`define TPC_ADDR_CTRL1   8'h04
`define TPC_ADDR_COUNT   8'h08
`define TPC_ADDR_CMPA    8'h0C
`define TPC_ADDR_CMPP    8'h10
`define TPC_ADDR_STATUS  8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TPC_C0_ON        0
`define TPC_C0_CKS_LO    1
`define TPC_C0_CKS_HI    2
`define TPC_C1_CLRSEL    0
`define TPC_C1_SWAP      1
`define TPC_C1_POL       2
`define TPC_C1_INIT      3
`define TPC_C1_PF_LO     4
`define TPC_C1_PF_HI     5
`define TPC_C1_MODE_LO   6
`define TPC_C1_MODE_HI   7
`define TPC_ST_MAF       0
`define TPC_ST_MPF       1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TPC_RST_CTRL0    3'h0
`define TPC_RST_CTRL1    8'h00
`define TPC_RST_CMPA     10'h000
`define TPC_RST_CMPP     3'h0

// ----------------------------------------------------------------------
// Codes of modes, pin functions and clock sources
// ----------------------------------------------------------------------
`define TPC_MODE_CAP     2'h1
`define TPC_MODE_PWM     2'h2
`define TPC_PF_INACT     2'h0
`define TPC_PF_ACT       2'h1
`define TPC_PF_PWM       2'h2
`define TPC_PF_PULSE     2'h3
`define TPC_CAP_RISE     2'h0
`define TPC_CAP_FALL     2'h1
`define TPC_CAP_BOTH     2'h2
`define TPC_CKS_DIV1     2'h0
`define TPC_CKS_DIV4     2'h1
`define TPC_CKS_DIV16    2'h2
`define TPC_CKS_EXT      2'h3
`define TPC_DIV4_LAST    4'h3
`define TPC_DIV16_LAST   4'hF

// ----------------------------------------------------------------------
// Timing counts in timer clock periods
// ----------------------------------------------------------------------
`define TPC_P_STEP       7'h00
`define TPC_FULL_COUNT   11'h400

`endif
